/* design/timer_burst_pkg.sv */
/*
  constants and carrier types for the timer burst and output
  configuration register bank.
  assumes a classic wishbone slave with 32-bit data.
*/
package timer_burst_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] FIRST_CTL_OFF  = 8'h00;
  localparam logic [7:0] CMP_OFF        = 8'h34;
  localparam logic [7:0] WRITE_LOCK_LEVEL_OFF       = 8'h44;
  localparam logic [7:0] BURST_CFG_OFF  = 8'he0;
  localparam logic [7:0] BURST_BUF_OFF  = 8'he4;
  localparam logic [7:0] OUT_CFG_OFF    = 8'hfc;
  // ==========================================================
  // field positions
  localparam int DT_LSB     = 0;
  localparam int IOS_BIT    = 10;
  localparam int LOCK_LSB   = 12;
  localparam int BSTART_LSB = 0;
  localparam int BCOUNT_LSB = 8;
  localparam int ODIS_BIT   = 0;
  localparam int FILT_BIT   = 1;
  // ==========================================================
  // reset values and limits
  localparam logic [7:0]  DT_RST     = 8'h00;
  localparam logic [1:0]  LOCK_RST   = 2'h0;
  localparam logic [1:0]  LOCK_OPEN  = 2'h0;
  localparam logic [5:0]  BURST_RST  = 6'h00;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [5:0]  BURST_MAX  = 6'h22;
  localparam int unsigned DTS_DIV    = 1;
  // ==========================================================
  // bus carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage : timer_burst_pkg

/* design/timer_burst_regs.sv */
/*
  register bank: dead-time code and its lock, idle off-state,
  dma burst redirection, compare write filter, an output disable bit that never changes the outputs.
  assumes a classic wishbone master on clk_sys, pwm references and
  channel enables from logic on the same clock.
*/
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`default_nettype none
module timer_burst_regs
  import timer_burst_pkg::*;
#(
  parameter int NCH    = 4,
  parameter int DTSDIV = DTS_DIV
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // register bus
  input  wire wb_req_t          wb_req,
  output wire wb_rsp_t          wb_rsp,
  // timer core side
  input  wire logic             primary_output_enable,
  input  wire logic [NCH-1:0]   chan_en,
  input  wire logic [NCH-1:0]   pwm_ref,
  output wire logic [1:0]       write_lock_level,
  // channel outputs
  output wire logic [NCH-1:0]   out_p,
  output wire logic [NCH-1:0]   out_n,
  output wire logic [NCH-1:0]   chan_oe,
  output wire logic [NCH-1:0]   cmp_updated
);
  initial begin
    if (NCH < 1 || NCH > 4 || DTSDIV < 1 || DTSDIV > 65536) begin
      $error("timer_burst_regs: unsupported parameters");
    end
  end

  // ==========================================================
  // reset release
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_sn = rst_s2_q;

  // ==========================================================
  // state
  logic [7:0]  dead_time_code_q;
  logic        idle_offstate_sel_q;
  logic [1:0]  lock_q;
  logic [5:0]  burst_start_index_q;
  logic [5:0]  burst_count_q;
  logic [5:0]  xfer_cnt_q;
  logic        compare_write_filter_q;
  logic        output_disable_sel_q;
  logic [15:0] cmp_q [NCH];
  logic        ack_q;
  logic [31:0] rdat_q;

  // ==========================================================
  // bus decode
  wire logic       req      = wb_req.cyc & wb_req.stb;
  wire logic       full_wd  = (wb_req.sel == 4'hf);
  wire logic       commit   = req & ack_q;
  wire logic [5:0] bus_idx  = wb_req.adr[7:2];
  wire logic       hit_buf  = (bus_idx == BURST_BUF_OFF[7:2]);
  wire logic [6:0] tgt_sum  = {1'b0, burst_start_index_q}
                            + {1'b0, xfer_cnt_q}
                            + {1'b0, FIRST_CTL_OFF[7:2]};
  wire logic       tgt_ok   = ~tgt_sum[6];
  wire logic [5:0] eff_idx  = hit_buf ? tgt_sum[5:0] : bus_idx;
  wire logic       eff_ok   = hit_buf ? tgt_ok & (tgt_sum[5:0] != bus_idx) : 1'b1;
  wire logic       wr       = commit & wb_req.we & full_wd & eff_ok;
  wire logic       hit_write_lock_level = (eff_idx == WRITE_LOCK_LEVEL_OFF[7:2]);
  wire logic       hit_bcfg = (eff_idx == BURST_CFG_OFF[7:2]);
  wire logic       hit_ocfg = (eff_idx == OUT_CFG_OFF[7:2]);
  wire logic [5:0] cmp_rel  = eff_idx - CMP_OFF[7:2];
  wire logic       hit_cmp  = (eff_idx >= CMP_OFF[7:2]) && (cmp_rel < 6'(NCH));
  wire logic       lock_open = (lock_q == LOCK_OPEN);
  wire logic [15:0] cmp_rd  = hit_cmp ? cmp_q[cmp_rel[1:0]] : 16'h0000;

  wire logic [31:0] write_lock_level_rd = {18'h0, lock_q, 1'b0, idle_offstate_sel_q,
                               2'b00, dead_time_code_q};
  wire logic [31:0] bcfg_rd = {18'h0, burst_count_q, 2'b00, burst_start_index_q};
  wire logic [31:0] ocfg_rd = {30'h0, compare_write_filter_q, output_disable_sel_q};
  wire logic [31:0] rd_mux  = !eff_ok  ? 32'h0 :
                              hit_write_lock_level ? write_lock_level_rd :
                              hit_bcfg ? bcfg_rd :
                              hit_ocfg ? ocfg_rd :
                              {16'h0, cmp_rd};

  assign wb_rsp.ack       = ack_q;
  assign wb_rsp.dat       = rdat_q;
  assign write_lock_level = lock_q;

  // ==========================================================
  // bus answer
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        rdat_q <= rd_mux;
      end
    end
  end

  // ==========================================================
  // protection fields
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      dead_time_code_q    <= DT_RST;
      idle_offstate_sel_q <= 1'b0;
      lock_q              <= LOCK_RST;
    end else if (wr && hit_write_lock_level) begin
      if (lock_open) begin
        dead_time_code_q <= wb_req.dat[DT_LSB +: 8];
        lock_q           <= wb_req.dat[LOCK_LSB +: 2];
      end
      if (!lock_q[1]) begin
        idle_offstate_sel_q <= wb_req.dat[IOS_BIT];
      end
    end
  end

  // ==========================================================
  // burst configuration and transfer count
  wire logic buf_done = commit & full_wd & hit_buf;
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      burst_start_index_q <= BURST_RST;
      burst_count_q       <= BURST_RST;
      xfer_cnt_q          <= BURST_RST;
    end else if (wr && hit_bcfg) begin
      burst_start_index_q <= wb_req.dat[BSTART_LSB +: 6];
      burst_count_q       <= wb_req.dat[BCOUNT_LSB +: 6];
      xfer_cnt_q          <= BURST_RST;
    end else if (buf_done) begin
      if (xfer_cnt_q >= burst_count_q) begin
        xfer_cnt_q <= BURST_RST;
      end else begin
        xfer_cnt_q <= xfer_cnt_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // output configuration
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      compare_write_filter_q <= 1'b0;
      output_disable_sel_q   <= 1'b0;
    end else if (wr && hit_ocfg) begin
      compare_write_filter_q <= wb_req.dat[FILT_BIT];
      output_disable_sel_q   <= wb_req.dat[ODIS_BIT];
    end
  end

  // ==========================================================
  // dead-time sampling tick
  logic [15:0] div_q;
  wire logic   dts_tick = (div_q == 16'(DTSDIV - 1));
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      div_q <= 16'h0;
    end else begin
      div_q <= dts_tick ? 16'h0 : div_q + 16'h1;
    end
  end

  // ==========================================================
  // dead-time length in ticks
  function automatic logic [9:0] dt_len(input logic [7:0] c);
    logic [9:0] r;
    r = 10'h0;
    casez (c[7:5])
      3'b0??:  r = {2'b00, c};
      3'b10?:  r = {2'b01, c[5:0], 1'b0};
      3'b110:  r = {2'b01, c[4:0], 3'b000};
      3'b111:  r = {1'b1, c[4:0], 4'b0000};
      default: r = 10'h0;
    endcase
    return r;
  endfunction : dt_len

  wire logic [9:0] dt_ticks = dt_len(dead_time_code_q);
  wire logic gate_ok = primary_output_enable | idle_offstate_sel_q;
  wire logic odis    = output_disable_sel_q & ~primary_output_enable
                     & ~idle_offstate_sel_q;

  // ==========================================================
  // per-channel compare, dead time and output gating
  logic [NCH-1:0] ref_q;
  logic [NCH-1:0] p_q;
  logic [NCH-1:0] n_q;
  logic [NCH-1:0] oe_q;
  logic [NCH-1:0] upd_q;
  logic [9:0]     dcnt_q [NCH];

  assign out_p       = p_q;
  assign out_n       = n_q;
  assign chan_oe     = oe_q;
  assign cmp_updated = upd_q;

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      wire logic sel_me = wr & hit_cmp & (cmp_rel == 6'(i));
      wire logic same   = (wb_req.dat[15:0] == cmp_q[i]);
      wire logic take   = sel_me & ~(compare_write_filter_q & same);
      wire logic idle   = (dcnt_q[i] == 10'h0);
      wire logic en     = chan_en[i] & gate_ok & ~odis;

      always_ff @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
          cmp_q[i] <= CMP_RST;
          upd_q[i] <= 1'b0;
        end else begin
          upd_q[i] <= take;
          if (take) begin
            cmp_q[i] <= wb_req.dat[15:0];
          end
        end
      end

      always_ff @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
          ref_q[i]  <= 1'b0;
          dcnt_q[i] <= 10'h0;
        end else begin
          ref_q[i] <= pwm_ref[i];
          if (pwm_ref[i] != ref_q[i]) begin
            dcnt_q[i] <= dt_ticks;
          end else if (dts_tick && !idle) begin
            dcnt_q[i] <= dcnt_q[i] - 10'h1;
          end
        end
      end

      always_ff @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
          p_q[i]  <= 1'b0;
          n_q[i]  <= 1'b0;
          oe_q[i] <= 1'b0;
        end else begin
          p_q[i]  <= en & idle & ref_q[i];
          n_q[i]  <= en & idle & ~ref_q[i];
          oe_q[i] <= en;
        end
      end
    end
  endgenerate
endmodule : timer_burst_regs
`default_nettype wire

/* tb/timer_burst_chk.sv */
/* port checker for timer_burst_regs.
   assumes it is bound to the top module. */
`timescale 1ns/100ps
`default_nettype none
module timer_burst_chk
  import timer_burst_pkg::*;
#(parameter int NCH = 4) (
  // clock and bus
  input wire logic           clk_sys,
  input wire logic           rst_n,
  input wire wb_req_t        wb_req,
  input wire wb_rsp_t        wb_rsp,
  // core side and outputs
  input wire logic           primary_output_enable,
  input wire logic [NCH-1:0] chan_en,
  input wire logic [NCH-1:0] pwm_ref,
  input wire logic [1:0]     write_lock_level,
  input wire logic [NCH-1:0] out_p,
  input wire logic [NCH-1:0] out_n,
  input wire logic [NCH-1:0] chan_oe,
  input wire logic [NCH-1:0] cmp_updated
);
  // ==========================================
  // helpers
  wire logic req, wacc, lock_wr;
  assign req = wb_req.cyc & wb_req.stb;
  assign wacc = req & wb_rsp.ack & wb_req.we;
  assign lock_wr = wacc & (wb_req.sel == 4'hf) & (wb_req.adr[7:2] == WRITE_LOCK_LEVEL_OFF[7:2])
                   & (write_lock_level == 2'h0);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // properties
  a_ack_follows: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack late");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  a_oe_subset: assert property ((chan_oe & ~$past(chan_en)) == '0)
    else $error("oe without enable");
  a_oe_primary_output_enable_on: assert property ($past(rst_n, 3) && $past(primary_output_enable)
    |-> chan_oe == $past(chan_en)) else $error("oe not following enable");
  a_no_overlap: assert property ((out_p & out_n) == '0)
    else $error("outputs overlap");
  a_lock_sticky: assert property (write_lock_level != 2'h0 |=> $stable(write_lock_level))
    else $error("lock changed");
  a_lock_taken: assert property (lock_wr |=> write_lock_level == $past(wb_req.dat[13:12]))
    else $error("lock not written");
  a_cmp_cause: assert property (cmp_updated != '0 |-> $past(wacc) || $past(wacc, 2))
    else $error("compare update without write");
  c_burst: cover property (wacc && wb_req.adr == BURST_BUF_OFF);
  c_cmp: cover property (cmp_updated != '0);
  c_lock: cover property (write_lock_level == 2'h2);
endmodule : timer_burst_chk
bind timer_burst_regs timer_burst_chk #(.NCH(NCH)) timer_burst_chk_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .primary_output_enable(primary_output_enable), .chan_en(chan_en), .pwm_ref(pwm_ref),
  .write_lock_level(write_lock_level), .out_p(out_p), .out_n(out_n), .chan_oe(chan_oe),
  .cmp_updated(cmp_updated));
`default_nettype wire

/* tb/wb_master_model.sv */
/* bus master standing in for cpu and dma controller.
   assumes a classic slave that acks each request. */
`timescale 1ns/100ps
`default_nettype none
module wb_master_model
  import timer_burst_pkg::*;
(
  // clock and bus
  input  wire logic    clk_sys,
  output var  wb_req_t wb_req,
  input  wire wb_rsp_t wb_rsp
);
  initial wb_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
    repeat ($urandom_range(3, 1)) @(posedge clk_sys);
    wb_req <= '{1'b1, 1'b1, w, a, s, d};
    do @(posedge clk_sys); while (wb_rsp.ack !== 1'b1);
    wb_req <= '0;
    @(posedge clk_sys);
  endtask : xfer
endmodule : wb_master_model
`default_nettype wire

/* tb/test_timer_burst_regs.sv */
/* bench for timer_burst_regs: bus, burst, filter, dead time, lock.
   assumes the bound checker and the bus master model. */
`timescale 1ns/100ps
`default_nettype none
module test_timer_burst_regs
  import timer_burst_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, primary_output_enable = 1'b1;
  logic [3:0] chan_en = 4'hf, pwm_ref = 4'h0, out_p, out_n, chan_oe, cmp_updated;
  logic [1:0] write_lock_level;
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  logic [31:0] exp_q[$];
  logic [15:0] v[4];
  logic [7:0] codes[6] = '{8'h00, 8'h7f, 8'ha3, 8'hc2, 8'he1, 8'h00};
  int bad_count, check_count, upd, k;
  always #25 clk_sys = ~clk_sys;
  timer_burst_regs timer_burst_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .primary_output_enable(primary_output_enable), .chan_en(chan_en),
    .pwm_ref(pwm_ref), .write_lock_level(write_lock_level), .out_p(out_p), .out_n(out_n),
    .chan_oe(chan_oe), .cmp_updated(cmp_updated));
  wb_master_model wb_master_model_inst (.clk_sys(clk_sys), .wb_req(wb_req), .wb_rsp(wb_rsp));
  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    wb_master_model_inst.xfer(1'b1, a, s, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_master_model_inst.xfer(1'b0, a, 4'hf, 32'h0);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  task automatic results;
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  function automatic int dtv(input logic [7:0] c);
    if (!c[7]) return int'(c);
    if (!c[6]) return (64 + int'(c[5:0])) * 2;
    return (32 + int'(c[4:0])) * (c[5] ? 16 : 8);
  endfunction : dtv
  // read results against the oldest note
  always @(posedge clk_sys)
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0)
      chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hx, wb_rsp.dat);
  always @(posedge clk_sys) if (cmp_updated[0] === 1'b1) upd++;
  initial begin
    #(40000 * 50);
    bad_count++;
    results();
  end
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(99855));
    codes[5] = 8'($urandom);
    do_reset();
    wr(8'h80, 32'hffff);
    rd(8'h80, 32'h0);
    rd(OUT_CFG_OFF, 32'h0);
    foreach (codes[i]) begin
      wr(WRITE_LOCK_LEVEL_OFF, {24'h0, codes[i]});
      @(posedge clk_sys) pwm_ref[0] <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
        #1;
      end while (out_p[0] !== 1'b1 && k < 1100);
      chk("dead_time", 32'(dtv(codes[i]) + 2), 32'(k));
      @(posedge clk_sys) pwm_ref[0] <= 1'b0;
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
        #1;
      end while (out_n[0] !== 1'b1 && k < 1100);
      chk("dead_time_n", 32'(dtv(codes[i]) + 2), 32'(k));
    end
    foreach (v[i]) v[i] = 16'($urandom);
    wr(BURST_CFG_OFF, 32'h040d);
    foreach (v[i]) wr(BURST_BUF_OFF, {16'h0, v[i]});
    wr(BURST_BUF_OFF, 32'h0);
    foreach (v[i]) rd(CMP_OFF + 8'(4 * i), {16'h0, v[i]});
    foreach (v[i]) rd(BURST_BUF_OFF, {16'h0, v[i]});
    rd(BURST_BUF_OFF, 32'h0);
    rd(BURST_BUF_OFF, {16'h0, v[0]});
    wr(OUT_CFG_OFF, 32'h3);
    wr(OUT_CFG_OFF, 32'h0, 4'h3);
    rd(OUT_CFG_OFF, 32'h3);
    upd = 0;
    wr(CMP_OFF, {16'h0, v[0]});
    wr(CMP_OFF, {16'h0, ~v[0]});
    settle();
    chk("cmp_updated", 32'h1, 32'(upd));
    @(posedge clk_sys) primary_output_enable <= 1'b0;
    chan_en <= 4'($urandom);
    wr(WRITE_LOCK_LEVEL_OFF, 32'h0);
    settle();
    chk("chan_oe", 32'h0, 32'(chan_oe));
    wr(WRITE_LOCK_LEVEL_OFF, 32'h400);
    settle();
    chk("chan_oe", 32'(chan_en), 32'(chan_oe));
    wr(WRITE_LOCK_LEVEL_OFF, 32'h1000);
    wr(WRITE_LOCK_LEVEL_OFF, 32'h0422);
    rd(WRITE_LOCK_LEVEL_OFF, 32'h1400);
    do_reset();
    wr(WRITE_LOCK_LEVEL_OFF, 32'h2411);
    wr(WRITE_LOCK_LEVEL_OFF, 32'h0);
    rd(WRITE_LOCK_LEVEL_OFF, 32'h2411);
    settle();
    chk("lock", 32'h2, 32'(write_lock_level));
    results();
  end
endmodule : test_timer_burst_regs
`default_nettype wire
